// file: rtl/led_ctrl_defines.svh
// constants for the led output control register bank
`ifndef LED_CTRL_DEFINES_SVH
`define LED_CTRL_DEFINES_SVH

`define REG_W            16
`define REG_SEL_W        1
`define SEL_CONTROL      1'h0
`define SEL_CROP_X       1'h1
`define CTL_ENABLE_BIT   0
`define CTL_FLIP_BIT     1
`define CTL_SKIP_LO      2
`define CTL_SKIP_HI      3
`define CTL_LOW_BYTE_COLOUR_SELECT_LO      4
`define CTL_LOW_BYTE_COLOUR_SELECT_HI      5
`define CTL_MIDDLE_BYTE_COLOUR_SELECT_LO      6
`define CTL_MIDDLE_BYTE_COLOUR_SELECT_HI      7
`define CTL_HSEL_LO      8
`define CTL_HSEL_HI      9
`define CTL_RSVD_LO      10
`define CTL_RSVD_HI      15
`define CROP_X_HI        10
`define CROP_RSVD_LO     11
`define CTL_RESET        16'h0001
`define CROP_X_RESET     16'h0000
`define SKIP_W           2
`define CROP_X_W         11
`define COLOUR_W         8
`define CODE_W           2
`define BYTE_LOW         2'h0
`define BYTE_MIDDLE      2'h1
`define BYTE_HIGH        2'h2

`endif

// file: rtl/led_ctrl_pkg.sv
// types shared by the led output control register bank
package led_ctrl_pkg;
	`include "led_ctrl_defines.svh"

	typedef enum logic [1:0] {
		sess_idle    = 2'b00,
		sess_modify  = 2'b01,
		sess_commit  = 2'b10
	} session_state_t;

	typedef struct packed {
		session_state_t           state;
		logic [`REG_W-1:0]        shadow_ctl;
		logic [`REG_W-1:0]        shadow_crop;
		logic [`REG_W-1:0]        live_ctl;
		logic [`REG_W-1:0]        live_crop;
		logic [`REG_W-1:0]        rd_data;
		logic                     out_enable;
		logic                     image_flip_bit;
		logic [`SKIP_W-1:0]       lead_pixel_skip_count;
		logic [`CROP_X_W-1:0]     crop_origin_horizontal;
		logic [3*`COLOUR_W-1:0]   pixel_out;
		logic                     pixel_out_valid;
	} bank_state_t;
endpackage

// file: rtl/colour_byte_mux.sv
// picks one colour channel for one output byte
`timescale 1ns/1ps
module colour_byte_mux #(
	parameter logic [1:0] CODE_BLUE_ALT = 2'h0
) (
	input  wire logic [1:0] sel,
	input  wire logic [7:0] red,
	input  wire logic [7:0] green,
	input  wire logic [7:0] blue,
	input  wire logic [1:0] order_base,
	output logic      [7:0] colour
);
	// order_base selects the code table: 0 low, 1 middle, 2 high byte
	logic [1:0] idx;
	always_comb begin
		idx = (sel == 2'h3) ? 2'h0 : sel;
		colour = blue;
		case (order_base)
		2'h0: begin
			case (idx)
			2'h1:    colour = green;
			2'h2:    colour = red;
			default: colour = blue;
			endcase
		end
		2'h1: begin
			case (idx)
			2'h1:    colour = red;
			2'h2:    colour = blue;
			default: colour = green;
			endcase
		end
		default: begin
			case (idx)
			2'h1:    colour = green;
			2'h2:    colour = blue;
			default: colour = red;
			endcase
		end
		endcase
	end
endmodule

// file: rtl/led_output_control_regs.sv
// control and crop-x register bank of the led strip output path
`timescale 1ns/1ps
`include "led_ctrl_defines.svh"
module led_output_control_regs #(
	parameter int REG_WIDTH    = `REG_W,
	parameter int SKIP_WIDTH   = `SKIP_W,
	parameter int CROP_WIDTH   = `CROP_X_W,
	parameter int COLOUR_WIDTH = `COLOUR_W
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	input  wire logic                   session_active,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [`REG_SEL_W-1:0]  reg_sel,
	input  wire logic [`REG_W-1:0]      reg_wdata,
	input  wire logic                   video_valid,
	input  wire logic [7:0]             pix_red,
	input  wire logic [7:0]             pix_green,
	input  wire logic [7:0]             pix_blue,
	input  wire logic                   pix_valid,
	output logic      [`REG_W-1:0]      reg_rdata,
	output logic                        out_enable,
	output logic                        image_flip_bit,
	output logic      [`SKIP_W-1:0]     lead_pixel_skip_count,
	output logic      [`CROP_X_W-1:0]   crop_origin_horizontal,
	output logic      [3*`COLOUR_W-1:0] pixel_out,
	output logic                        pixel_out_valid
);
	import led_ctrl_pkg::*;

	bank_state_t cur;
	bank_state_t next_cur;
	logic [7:0]  low_colour;
	logic [7:0]  mid_colour;
	logic [7:0]  high_colour;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// ports and fields are laid out for the documented widths only
	if (REG_WIDTH != `REG_W) begin
		$error("register width must equal the bank word");
	end
	if (REG_WIDTH <= `CTL_HSEL_HI) begin
		$error("register too narrow for the control fields");
	end
	if (REG_WIDTH <= `CROP_X_HI) begin
		$error("register too narrow for the crop field");
	end
	if (SKIP_WIDTH != `CODE_W) begin
		$error("skip count width must equal the field width");
	end
	if (CROP_WIDTH != `CROP_X_HI + 1) begin
		$error("crop width must match the crop field");
	end
	if (CROP_WIDTH > REG_WIDTH) begin
		$error("crop width cannot exceed the register width");
	end
	if (COLOUR_WIDTH != `COLOUR_W) begin
		$error("colour width must be one byte");
	end

	// ----------------------------------------
	// field decoding
	// ----------------------------------------
	// two-bit field of a control word starting at bit lo
	function automatic logic [`CODE_W-1:0] two_bit_field(
		input logic [`REG_W-1:0] word,
		input int unsigned       lo
	);
		two_bit_field = word[lo +: `CODE_W];
	endfunction

	// readback word: control bit 0 reports video status
	function automatic logic [`REG_W-1:0] readback_word(
		input logic [`REG_SEL_W-1:0] sel,
		input logic [`REG_W-1:0]     ctl_word,
		input logic [`REG_W-1:0]     crop_word,
		input logic                  status
	);
		logic [`REG_W-1:0] word;
		// crop reads back whole, reserved bits too
		word = crop_word;
		if (sel == `SEL_CONTROL) begin
			word                  = ctl_word;
			word[`CTL_ENABLE_BIT] = status;
		end
		return word;
	endfunction

	// commit step: the cycle after leaving the modify session
	function automatic logic is_commit(input session_state_t st);
		is_commit = (st == sess_commit);
	endfunction

	// session tracker: modify while open, one commit step after it
	function automatic session_state_t session_step(
		input session_state_t st,
		input logic           active
	);
		session_state_t nx;
		case (st)
		sess_idle:   nx = active ? sess_modify : sess_idle;
		sess_modify: nx = active ? sess_modify : sess_commit;
		sess_commit: nx = active ? sess_modify : sess_idle;
		// unused code falls back to idle
		default:     nx = sess_idle;
		endcase
		return nx;
	endfunction

	// ----------------------------------------
	// colour order from live settings
	// ----------------------------------------
	colour_byte_mux low_mux (
		.sel        (two_bit_field(cur.live_ctl, `CTL_LOW_BYTE_COLOUR_SELECT_LO)),
		.red        (pix_red),
		.green      (pix_green),
		.blue       (pix_blue),
		.order_base (`BYTE_LOW),
		.colour     (low_colour)
	);
	colour_byte_mux mid_mux (
		.sel        (two_bit_field(cur.live_ctl, `CTL_MIDDLE_BYTE_COLOUR_SELECT_LO)),
		.red        (pix_red),
		.green      (pix_green),
		.blue       (pix_blue),
		.order_base (`BYTE_MIDDLE),
		.colour     (mid_colour)
	);
	colour_byte_mux high_mux (
		.sel        (two_bit_field(cur.live_ctl, `CTL_HSEL_LO)),
		.red        (pix_red),
		.green      (pix_green),
		.blue       (pix_blue),
		.order_base (`BYTE_HIGH),
		.colour     (high_colour)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		// everything holds while the clock enable is low
		next_cur = cur;
		if (clk_en) begin
			// session tracking: commit on leaving modify
			next_cur.state = session_step(cur.state, session_active);

			if (reg_wr) begin
				// whole word kept, reserved bits included
				if (reg_sel == `SEL_CONTROL)
					next_cur.shadow_ctl = reg_wdata;
				else
					next_cur.shadow_crop = reg_wdata;
			end

			// a write in the commit step waits for the next session
			if (is_commit(cur.state)) begin
				next_cur.live_ctl  = cur.shadow_ctl;
				next_cur.live_crop = cur.shadow_crop;
			end

			// readback registered; holds until the next read
			if (reg_rd) begin
				next_cur.rd_data = readback_word(reg_sel,
					cur.shadow_ctl, cur.shadow_crop,
					video_valid);
			end

			// enable needs both software permission and valid video
			next_cur.out_enable = cur.live_ctl[`CTL_ENABLE_BIT]
				&& video_valid;
			next_cur.image_flip_bit =
				cur.live_ctl[`CTL_FLIP_BIT];
			next_cur.lead_pixel_skip_count =
				two_bit_field(cur.live_ctl, `CTL_SKIP_LO);
			next_cur.crop_origin_horizontal =
				cur.live_crop[`CROP_X_HI:0];
			// byte order follows the live selectors, not the shadow
			next_cur.pixel_out = {high_colour, mid_colour, low_colour};
			next_cur.pixel_out_valid = pix_valid && cur.out_enable;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// reset takes no notice of the clock enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur                        <= '0;
			cur.state                  <= sess_idle;
			cur.shadow_ctl             <= `CTL_RESET;
			cur.live_ctl               <= `CTL_RESET;
			cur.shadow_crop            <= `CROP_X_RESET;
			cur.live_crop              <= `CROP_X_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// outputs straight from the state register
	// ----------------------------------------
	assign reg_rdata              = cur.rd_data;
	assign out_enable             = cur.out_enable;
	assign image_flip_bit         = cur.image_flip_bit;
	assign lead_pixel_skip_count  = cur.lead_pixel_skip_count;
	assign crop_origin_horizontal = cur.crop_origin_horizontal;
	assign pixel_out              = cur.pixel_out;
	assign pixel_out_valid        = cur.pixel_out_valid;
endmodule

// file: tb/led_ctrl_asserts.sv
// assertion checker for the led output control register bank
`timescale 1ns/1ps
module led_ctrl_asserts
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic        session_active,
	input wire logic        reg_rd,
	input wire logic [0:0]  reg_sel,
	input wire logic        video_valid,
	input wire logic        pix_valid,
	input wire logic [15:0] reg_rdata,
	input wire logic        out_enable,
	input wire logic        image_flip_bit,
	input wire logic [1:0]  lead_pixel_skip_count,
	input wire logic [10:0] crop_origin_horizontal,
	input wire logic        pixel_out_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_rd_status: assert property (reg_rd && clk_en && !reg_sel |=>
		reg_rdata[0] == $past(video_valid)) else $error("status bit");
	a_rd_hold: assert property (!(reg_rd && clk_en) |=>
		$stable(reg_rdata)) else $error("readback moved");
	a_no_video: assert property (clk_en && !video_valid |=>
		!out_enable) else $error("enable without video");
	a_flip_commit: assert property (!$stable(image_flip_bit) |->
		$past(session_active, 4) && !$past(session_active, 3)) else $error("flip");
	a_skip_commit: assert property (!$stable(lead_pixel_skip_count) |->
		$past(session_active, 4) && !$past(session_active, 3)) else $error("skip");
	a_crop_commit: assert property (!$stable(crop_origin_horizontal) |->
		$past(session_active, 4) && !$past(session_active, 3)) else $error("crop");
	a_pix_gate: assert property (clk_en |=> pixel_out_valid ==
		$past(pix_valid && out_enable)) else $error("pixel valid");
	a_reset_clear: assert property ($fell(rst) |->
		crop_origin_horizontal == 11'h000 && !image_flip_bit) else $error("reset");
endmodule
bind led_output_control_regs led_ctrl_asserts chk (.*);

// file: tb/test_led_output_control_regs.sv
// self-checking bench for the led output control register bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_led_output_control_regs;
	logic        core_clk = 0, rst = 1, clk_en = 1, ses = 0, wr = 0, rd = 0;
	logic        sel = 0, vv = 1, pv = 1, en, flip, pov;
	logic [15:0] wd = 0, rdata;
	logic [1:0]  skip;
	logic [10:0] crop;
	logic [23:0] pix;
	int          failures = 0, n_compared = 0;
	logic [15:0] ctl [5] = '{16'h001, 16'h143, 16'h09d, 16'h3f5, 16'hfea9};
	logic [23:0] exp [5] = '{24'h112233, 24'h221133, 24'h113322, 24'h112233,
		24'h333311};
	led_output_control_regs DUT (.core_clk, .rst, .clk_en, .session_active(ses),
		.reg_wr(wr), .reg_rd(rd), .reg_sel(sel), .reg_wdata(wd),
		.video_valid(vv), .pix_red(8'h11), .pix_green(8'h22),
		.pix_blue(8'h33), .pix_valid(pv), .reg_rdata(rdata), .out_enable(en),
		.image_flip_bit(flip), .lead_pixel_skip_count(skip),
		.crop_origin_horizontal(crop), .pixel_out(pix), .pixel_out_valid(pov));
	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic put(logic s, logic [15:0] d, logic w);
		sel = s; wd = d; wr = w; rd = !w;
		cyc(1);
		wr = 0; rd = 0;
		cyc(1);
	endtask
	task automatic commit(logic s, logic [15:0] d);
		ses = 1;
		put(s, d, 1);
		ses = 0;
		cyc(4);
	endtask
	task automatic conclude();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial forever #12.5 core_clk = ~core_clk;
	initial begin
		#50us;
		$display("[ERR] %0t watchdog expired", $time);
		failures++;
		conclude();
	end
	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	initial begin
		cyc(20);
		rst = 0;
		cyc(1);
		put(0, 0, 0); `CHK(rdata, 16'h0001)
		put(1, 0, 0); `CHK({rdata, crop}, 27'h0)
		$display("reset test done");
		foreach (ctl[i]) begin
			commit(0, ctl[i]);
			`CHK(en, 1'b1)
			`CHK(flip, ctl[i][1])
			`CHK(skip, ctl[i][3:2])
			`CHK(pix, exp[i])
			put(0, 0, 0); `CHK(rdata, ctl[i])
		end
		$display("row test done");
		ses = 1; put(1, 16'hffff, 1); cyc(4); `CHK(crop, 11'h000)
		ses = 0; cyc(4); `CHK(crop, 11'h7ff)
		put(1, 0, 0); `CHK(rdata, 16'hffff)
		$display("session test done");
		commit(0, 16'h0000); `CHK({en, pov}, 2'b00)
		put(0, 0, 0); `CHK(rdata[0], 1'b1)
		vv = 0; put(0, 0, 0); `CHK(rdata[0], 1'b0)
		commit(0, 16'h0001); `CHK(en, 1'b0)
		vv = 1; cyc(3); `CHK({en, pov}, 2'b11)
		pv = 0; cyc(2); `CHK(pov, 1'b0)
		pv = 1;
		clk_en = 0;
		put(1, 16'h0123, 1);
		put(1, 0, 0); `CHK(rdata, 16'h0000)
		clk_en = 1;
		put(1, 0, 0); `CHK(rdata, 16'hffff)
		rst = 1; cyc(2); rst = 0; cyc(1); `CHK({crop, flip}, 12'h0)
		$display("enable test done");
		conclude();
	end
endmodule
